//--- rbds_sequencer.sv
// Reset release, boot download, deep sleep and request pulse sequencer.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module rbds_sequencer #(
    parameter int ERASE_EXT = rbds_pkg::ERASE_EXT_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire rbds_pkg::rbds_bus_req_t bus_req,
    output logic [rbds_pkg::DATA_W-1:0] bus_rdata,
    output logic flash_rd_req,
    output logic [rbds_pkg::RAM_AW-1:0] flash_rd_addr,
    input wire rbds_pkg::rbds_flash_rsp_t flash_rsp,
    input wire logic flash_erase_busy,
    input wire logic deep_sleep_control,
    input wire logic dma_trigger,
    output logic download_pending,
    output logic transfer_request_out,
    output logic irq_n
);
    import rbds_pkg::*;

    rbds_state_t state;
    logic [WAIT_W-1:0] wait_cnt;
    logic [RAM_AW-1:0] load_addr;
    logic load_waiting;
    logic [GUARD_W-1:0] guard_cnt;
    logic erase_ext;
    logic first_cycle;
    logic dsc_q;
    logic pend_valid;
    logic [RAM_AW-1:0] pend_addr;
    logic [1:0] ctrl;
    logic dma_ctrl;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_mask;
    logic [DATA_W-1:0] reg_rdata;
    logic sel_ram;
    logic ram_we;
    logic [RAM_AW-1:0] ram_waddr;
    logic [DATA_W-1:0] ram_wdata;
    logic ram_re;
    logic [RAM_AW-1:0] ram_raddr;
    logic [DATA_W-1:0] ram_q;
    logic host_ok;
    logic reg_hit;
    logic ram_hit;
    logic [EV_W-1:0] ev;
    logic irq_any;
    logic irq_any_q;
    logic irq_pulse;
    logic dma_pulse;
    logic wake_edge;
    logic load_last;

    localparam logic [WAIT_W-1:0] ERASE_EXT_W = WAIT_W'(ERASE_EXT);
    localparam logic [GUARD_W-1:0] GUARD_RELOAD = GUARD_W'(DATA_VALID_CYC);

    // Register window match on a full address.
    function automatic logic reg_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        reg_is = (a == off);
    endfunction

    // Boot memory word address taken from a bus address.
    function automatic logic [RAM_AW-1:0] ram_word(input logic [ADDR_W-1:0] a);
        ram_word = a[RAM_AW-1:0];
    endfunction

    // Host accesses other than status reads are honoured only once the copy is over and data can be valid.
    assign host_ok = (state == SQ_READY) && (guard_cnt == {GUARD_W{1'b0}});
    assign reg_hit = bus_req.addr[REG_SEL_BIT];
    assign ram_hit = !bus_req.addr[REG_SEL_BIT];
    assign wake_edge = (state == SQ_SLEEP) && (deep_sleep_control != dsc_q);
    assign load_last = (load_addr == RAM_AW'(RAM_WORDS - 1));

    // Previous level of the deep-sleep control; a change in either direction wakes.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dsc_q <= 1'b0;
        end else begin
            dsc_q <= deep_sleep_control;
        end
    end

    // Marks the first edge after release so the erase state can be sampled then.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    // Main sequence: reset holds everything, release starts the copy.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= SQ_ERASE_WAIT;
            wait_cnt <= {WAIT_W{1'b0}};
        end else begin
            case (state)
                SQ_ERASE_WAIT: begin
                    // An interrupted erase is allowed to finish, within a bounded extension.
                    if (flash_erase_busy && (wait_cnt < ERASE_EXT_W)) begin
                        wait_cnt <= wait_cnt + WAIT_W'(1);
                    end else begin
                        state <= SQ_LOAD;
                    end
                end
                SQ_LOAD: begin
                    if (flash_rsp.valid && load_last) begin
                        state <= SQ_FINISH;
                    end
                end
                SQ_FINISH: begin
                    state <= SQ_READY;
                end
                SQ_READY: begin
                    if (bus_req.wr && host_ok && reg_is(bus_req.addr, REG_CTRL)
                            && bus_req.wdata[CTRL_SLEEP_ENTER]) begin
                        state <= SQ_SLEEP;
                    end
                end
                SQ_SLEEP: begin
                    if (wake_edge) begin
                        state <= SQ_READY;
                    end
                end
                default: begin
                    state <= SQ_ERASE_WAIT;
                end
            endcase
        end
    end

    // Records that release found an erase running, for software to see.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            erase_ext <= 1'b0;
        end else if (first_cycle) begin
            erase_ext <= flash_erase_busy;
        end
    end

    // Flash fetch: one outstanding read at a time, word by word.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            load_addr <= {RAM_AW{1'b0}};
            load_waiting <= 1'b0;
            flash_rd_req <= 1'b0;
        end else begin
            flash_rd_req <= 1'b0;
            if (state == SQ_LOAD) begin
                if (!load_waiting) begin
                    flash_rd_req <= 1'b1;
                    load_waiting <= 1'b1;
                end else if (flash_rsp.valid) begin
                    load_waiting <= 1'b0;
                    if (!load_last) begin
                        load_addr <= load_addr + RAM_AW'(1);
                    end
                end
            end
        end
    end

    assign flash_rd_addr = load_addr;

    // Data-valid guard counts down after release and after each wake.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            guard_cnt <= GUARD_RELOAD;
        end else if (wake_edge) begin
            guard_cnt <= GUARD_RELOAD;
        end else if (guard_cnt != {GUARD_W{1'b0}}) begin
            guard_cnt <= guard_cnt - GUARD_W'(1);
        end
    end

    // The first boot-memory read during the copy is held and served as it ends.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend_valid <= 1'b0;
            pend_addr <= {RAM_AW{1'b0}};
        end else if (state == SQ_FINISH) begin
            pend_valid <= 1'b0;
        end else if (bus_req.rd && ram_hit && download_pending && !pend_valid) begin
            pend_valid <= 1'b1;
            pend_addr <= ram_word(bus_req.addr);
        end
    end

    // Wait output and loader flag are one flop, so they can never disagree.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            download_pending <= 1'b1;
        end else if (state == SQ_FINISH) begin
            download_pending <= 1'b0;
        end
    end

    // Boot memory ports: the copy writes, the host reads and writes when allowed.
    always_comb begin
        ram_we = 1'b0;
        ram_waddr = load_addr;
        ram_wdata = flash_rsp.data;
        ram_re = 1'b0;
        ram_raddr = ram_word(bus_req.addr);
        if (state == SQ_LOAD && load_waiting && flash_rsp.valid) begin
            ram_we = 1'b1;
        end else if (bus_req.wr && ram_hit && host_ok) begin
            ram_we = 1'b1;
            ram_waddr = ram_word(bus_req.addr);
            ram_wdata = bus_req.wdata;
        end
        if (state == SQ_FINISH && pend_valid) begin
            ram_re = 1'b1;
            ram_raddr = pend_addr;
        end else if (bus_req.rd && ram_hit && host_ok) begin
            ram_re = 1'b1;
        end
    end

    rbds_boot_ram u_ram (
        .clk(clk),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .re(ram_re),
        .raddr(ram_raddr),
        .rdata(ram_q)
    );

    // Control and DMA polarity registers; writes before ready are dropped.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= CTRL_RESET;
            dma_ctrl <= DMA_CTRL_RESET;
            irq_mask <= IRQ_MASK_RESET;
        end else if (bus_req.wr && host_ok) begin
            if (reg_is(bus_req.addr, REG_CTRL)) begin
                ctrl <= {bus_req.wdata[CTRL_IRQ_EDGE], 1'b0};
            end else if (reg_is(bus_req.addr, REG_DMA_CTRL)) begin
                dma_ctrl <= bus_req.wdata[DMA_POLARITY];
            end else if (reg_is(bus_req.addr, REG_IRQ_MASK)) begin
                irq_mask <= bus_req.wdata[EV_W-1:0];
            end
        end
    end

    // Events of this block.
    assign ev[EV_LOAD_DONE] = (state == SQ_FINISH);
    assign ev[EV_WAKE] = wake_edge;
    assign ev[EV_DMA_REQ] = dma_trigger && !dma_pulse;

    // Sticky status; a new event in the clearing cycle survives the clear.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_status <= {EV_W{1'b0}};
        end else if (bus_req.wr && host_ok && reg_is(bus_req.addr, REG_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~bus_req.wdata[EV_W-1:0]) | ev;
        end else begin
            irq_status <= irq_status | ev;
        end
    end

    assign irq_any = |(irq_status & irq_mask);

    // Edge mode needs the previous level to spot a new request.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_any_q <= 1'b0;
        end else begin
            irq_any_q <= irq_any;
        end
    end

    rbds_pulse u_irq_pulse (
        .clk(clk),
        .rstn(rstn),
        .start(irq_any && !irq_any_q),
        .active(irq_pulse)
    );

    rbds_pulse u_dma_pulse (
        .clk(clk),
        .rstn(rstn),
        .start(dma_trigger),
        .active(dma_pulse)
    );

    // Interrupt pin: fixed pulse in edge mode, level otherwise; active low.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_n <= 1'b1;
        end else if (ctrl[CTRL_IRQ_EDGE]) begin
            irq_n <= !irq_pulse;
        end else begin
            irq_n <= !irq_any;
        end
    end

    // Request pin polarity follows the DMA control bit; idle is the inactive level.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            transfer_request_out <= 1'b1;
        end else begin
            transfer_request_out <= dma_pulse ~^ dma_ctrl;
        end
    end

    // Register read data; refused or unmapped reads answer zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= {DATA_W{1'b0}};
            sel_ram <= 1'b0;
        end else begin
            reg_rdata <= {DATA_W{1'b0}};
            sel_ram <= 1'b0;
            if (state == SQ_FINISH && pend_valid) begin
                sel_ram <= 1'b1;
            end else if (bus_req.rd && reg_hit) begin
                if (reg_is(bus_req.addr, REG_STATUS)) begin
                    // Status stays readable during the copy so software can poll it.
                    reg_rdata[ST_LOADER_ACTIVE] <= download_pending;
                    reg_rdata[ST_SLEEPING] <= (state == SQ_SLEEP);
                    reg_rdata[ST_DATA_READY] <= host_ok;
                    reg_rdata[ST_ERASE_EXT] <= erase_ext;
                end else if (!host_ok) begin
                    reg_rdata <= {DATA_W{1'b0}};
                end else if (reg_is(bus_req.addr, REG_CTRL)) begin
                    reg_rdata[CTRL_IRQ_EDGE] <= ctrl[CTRL_IRQ_EDGE];
                end else if (reg_is(bus_req.addr, REG_DMA_CTRL)) begin
                    reg_rdata[DMA_POLARITY] <= dma_ctrl;
                end else if (reg_is(bus_req.addr, REG_IRQ_STATUS)) begin
                    reg_rdata[EV_W-1:0] <= irq_status;
                end else if (reg_is(bus_req.addr, REG_IRQ_MASK)) begin
                    reg_rdata[EV_W-1:0] <= irq_mask;
                end
            end else if (bus_req.rd && ram_hit && host_ok) begin
                sel_ram <= 1'b1;
            end
        end
    end

    // Both sources are flops; the select only picks which one answers.
    assign bus_rdata = sel_ram ? ram_q : reg_rdata;
endmodule
`default_nettype wire

//--- rbds_pkg.sv
// Package with the constants, types and timing counts of the reset and boot download sequencer.
//
// Contract
// - Holding the hard reset input low keeps the block in reset.
// - Releasing reset starts copying boot code from flash into boot memory.
// - Host reads and writes are ignored while the boot copy runs; status reads are still answered.
// - Loader-active flag reads 1 during the copy, 0 once download-pending negates.
// - Reset during a flash erase may stretch the ready time by 500 us.
// - A stalled first read has valid data when download-pending negates.
// - In edge mode each interrupt pulse lasts 250 ns to 500 ns.
// - Bit 0 of the DMA control register selects transfer request polarity.
// - Each transfer request pulse lasts 250 ns to 500 ns.
// - Read data is valid no sooner than 660 ns after wake or release.
package rbds_pkg;

    // Clock and widths.
    localparam int CLK_NS = 4;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int RAM_AW = 10;
    localparam int RAM_WORDS = 1024;

    // Register window: address bit 11 high selects registers, low selects boot memory.
    localparam int REG_SEL_BIT = 11;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h800;
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h801;
    localparam logic [ADDR_W-1:0] REG_DMA_CTRL = 12'h802;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 12'h803;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 12'h804;

    // Status fields.
    localparam int ST_LOADER_ACTIVE = 0;
    localparam int ST_SLEEPING = 1;
    localparam int ST_DATA_READY = 2;
    localparam int ST_ERASE_EXT = 3;
    // Control fields.
    localparam int CTRL_SLEEP_ENTER = 0;
    localparam int CTRL_IRQ_EDGE = 1;
    // DMA control field: 1 makes the request active high.
    localparam int DMA_POLARITY = 0;
    // Interrupt event bits.
    localparam int EV_W = 3;
    localparam int EV_LOAD_DONE = 0;
    localparam int EV_WAKE = 1;
    localparam int EV_DMA_REQ = 2;

    // Reset values.
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic DMA_CTRL_RESET = 1'b0;
    localparam logic [EV_W-1:0] IRQ_MASK_RESET = 3'h0;

    // Timing figures in their own units and derived cycle counts.
    localparam int PULSE_MIN_NS = 250;
    localparam int PULSE_MAX_NS = 500;
    localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_NS;
    localparam int DATA_VALID_NS = 660;
    localparam int DATA_VALID_CYC = (DATA_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_GAP_NS = 600;
    localparam int STROBE_GAP_CYC = (STROBE_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int READY_MAX_US = 1055;
    localparam int ERASE_EXT_US = 500;
    localparam int ERASE_EXT_CYC = ERASE_EXT_US * 1000 / CLK_NS;
    localparam int RESET_MIN_NS = 30;
    localparam int GUARD_W = 8;
    localparam int WAIT_W = 17;

    // Host register bus request.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rbds_bus_req_t;

    // Flash array read answer.
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } rbds_flash_rsp_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        SQ_ERASE_WAIT,
        SQ_LOAD,
        SQ_FINISH,
        SQ_READY,
        SQ_SLEEP
    } rbds_state_t;

endpackage

//--- rbds_boot_ram.sv
// Boot block memory with one write port and one registered read port.
`timescale 1ns/1ns
`default_nettype none
module rbds_boot_ram (
    input wire logic clk,
    input wire logic we,
    input wire logic [rbds_pkg::RAM_AW-1:0] waddr,
    input wire logic [rbds_pkg::DATA_W-1:0] wdata,
    input wire logic re,
    input wire logic [rbds_pkg::RAM_AW-1:0] raddr,
    output logic [rbds_pkg::DATA_W-1:0] rdata
);
    import rbds_pkg::*;

    logic [DATA_W-1:0] mem [RAM_WORDS];

    // Write port; contents carry no reset, the download fills them.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data leave through a register so the bus answer is a flop.
    always_ff @(posedge clk) begin
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

//--- rbds_pulse.sv
// One-shot that stretches a start pulse into a fixed-width pulse.
`timescale 1ns/1ns
`default_nettype none
module rbds_pulse (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    output logic active
);
    import rbds_pkg::*;

    localparam logic [7:0] WIDTH = 8'(PULSE_CYC);
    logic [7:0] cnt;

    // A start during a running pulse is dropped rather than merged, so no pulse runs long.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 8'h00;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end else if (start) begin
            cnt <= WIDTH;
        end
    end

    assign active = (cnt != 8'h00);
endmodule
`default_nettype wire

//--- rbds_monitor.sv
// Port checker for the reset and boot download sequencer.
`timescale 1ns/1ns
`default_nettype none
module rbds_monitor #(
    parameter int ERASE_EXT = rbds_pkg::ERASE_EXT_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire rbds_pkg::rbds_bus_req_t bus_req,
    input wire logic [rbds_pkg::DATA_W-1:0] bus_rdata,
    input wire logic flash_rd_req,
    input wire logic [rbds_pkg::RAM_AW-1:0] flash_rd_addr,
    input wire rbds_pkg::rbds_flash_rsp_t flash_rsp,
    input wire logic flash_erase_busy,
    input wire logic download_pending,
    input wire logic transfer_request_out,
    input wire logic irq_n
);
    import rbds_pkg::*;

    // One clock domain, so clock and reset are given once for every check.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // First edge after reset release, and a register read of the status word.
    sequence s_release;
        $rose(rstn);
    endsequence
    sequence s_status_rd;
        $past(bus_req.rd) && ($past(bus_req.addr) == REG_STATUS);
    endsequence

    reset_pend_a: assert property (s_release |-> download_pending)
        else $error("download pending low right after reset");
    reset_quiet_a: assert property (s_release |-> irq_n && transfer_request_out && !flash_rd_req)
        else $error("outputs not idle right after reset");
    fetch_first_a: assert property (s_release ##0 !flash_erase_busy |-> ##[1:4] flash_rd_req && flash_rd_addr == '0)
        else $error("copy did not start at word zero");
    // An answer moves the address on; the next fetch follows a cycle later.
    fetch_next_a: assert property (flash_rsp.valid && download_pending && flash_rd_addr != 10'h3FF
        |=> flash_rd_addr == $past(flash_rd_addr) + 10'h001 ##1 flash_rd_req)
        else $error("fetch sequence broken");
    pend_fall_a: assert property ($fell(download_pending) |-> $past(flash_rsp.valid, 2)
        && $past(flash_rd_addr, 2) == 10'h3FF)
        else $error("download pending fell before the last word");
    busy_quiet_a: assert property (download_pending && $past(bus_req.rd) && $past(bus_req.addr[REG_SEL_BIT])
        && $past(bus_req.addr) != REG_STATUS |-> bus_rdata == '0)
        else $error("register read answered during copy");
    status_flag_a: assert property (s_status_rd ##0 !$past(download_pending) |-> !bus_rdata[ST_LOADER_ACTIVE])
        else $error("loader flag set after download pending fell");
    erase_hold_a: assert property (s_release ##0 flash_erase_busy |-> !flash_rd_req [*8])
        else $error("copy started during erase extension");
endmodule
`default_nettype wire

//--- rbds_flash_model.sv
// Flash array model answering one word fetch after a set latency.
`timescale 1ns/1ns
`default_nettype none
module rbds_flash_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] lat,
    input wire logic flash_rd_req,
    input wire logic [rbds_pkg::RAM_AW-1:0] flash_rd_addr,
    output rbds_pkg::rbds_flash_rsp_t flash_rsp
);
    import rbds_pkg::*;
    logic busy;
    logic [3:0] wait_cnt;
    logic [RAM_AW-1:0] addr_q;

    // Between answers the data lines toggle every cycle between the inverse of the last word and the word.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            wait_cnt <= 4'h0;
            addr_q <= '0;
            flash_rsp <= '0;
        end else if (busy && wait_cnt <= 4'h1) begin
            busy <= 1'b0;
            flash_rsp <= {1'b1, ~addr_q[5:0], addr_q};
        end else begin
            flash_rsp <= {1'b0, ~flash_rsp.data};
            wait_cnt <= wait_cnt - 4'h1;
            if (flash_rd_req && !busy) begin
                busy <= 1'b1;
                addr_q <= flash_rd_addr;
                wait_cnt <= lat;
            end
        end
    end
endmodule
`default_nettype wire

//--- rbds_sequencer_bench.sv
// Self-checking bench for the reset and boot download sequencer.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t got %h expected %h", $time, (a), (b)); end end
module rbds_sequencer_bench;
    import rbds_pkg::*;
    localparam int EXT = 20;
    logic clk, rstn, flash_erase_busy, deep_sleep_control, dma_trigger;
    logic download_pending, transfer_request_out, irq_n, flash_rd_req;
    logic [3:0] lat;
    logic [DATA_W-1:0] bus_rdata;
    logic [RAM_AW-1:0] flash_rd_addr;
    rbds_bus_req_t bus_req;
    rbds_flash_rsp_t flash_rsp;
    int err_count = 0;
    int n_tests = 0;
    int cyc_count = 0;

    rbds_sequencer #(.ERASE_EXT(EXT)) i_rbds_sequencer (.clk(clk), .rstn(rstn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
        .flash_rsp(flash_rsp), .flash_erase_busy(flash_erase_busy), .deep_sleep_control(deep_sleep_control),
        .dma_trigger(dma_trigger), .download_pending(download_pending),
        .transfer_request_out(transfer_request_out), .irq_n(irq_n));
    rbds_flash_model i_rbds_flash_model (.clk(clk), .rstn(rstn), .lat(lat), .flash_rd_req(flash_rd_req),
        .flash_rd_addr(flash_rd_addr), .flash_rsp(flash_rsp));

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Word the flash model returns for an address.
    function automatic logic [DATA_W-1:0] fw(input logic [RAM_AW-1:0] a);
        return {~a[5:0], a};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        bus_req <= '{1'b0, 1'b1, a, d};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the taking edge, so they are sampled just after it.
    task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        bus_req <= '{1'b1, 1'b0, a, 16'h0000};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    task automatic trig;
        @(posedge clk);
        dma_trigger <= 1'b1;
        @(posedge clk);
        dma_trigger <= 1'b0;
    endtask

    // Counts the cycles one pulse of an output spends at the given level.
    task automatic measure(input bit on_irq, input logic lvl, output int n);
        int k;
        n = 0;
        for (k = 0; k < 300; k++) begin
            step(1);
            if ((on_irq ? irq_n : transfer_request_out) === lvl) n++;
            else if (n > 0) break;
        end
    endtask

    task automatic do_reset(input logic erase);
        @(posedge clk);
        rstn <= 1'b0;
        flash_erase_busy <= erase;
        step(7);
        `CHK(download_pending, 1'b1)
        `CHK({irq_n, transfer_request_out}, 2'h3)
        @(posedge clk);
        rstn <= 1'b1;
    endtask

    task automatic wait_fall;
        int k;
        for (k = 0; k < 8000 && download_pending !== 1'b0; k++) step(1);
    endtask

    task automatic t_boot;
        logic [DATA_W-1:0] d;
        lat = 4'h1;
        do_reset(1'b0);
        step(200);
        bus_wr(REG_IRQ_MASK, 16'h0007);
        bus_rd(REG_STATUS, d);
        `CHK(d[ST_LOADER_ACTIVE], 1'b1)
        bus_rd(REG_IRQ_MASK, d);
        `CHK(d, 16'h0000)
        bus_rd(12'h005, d);
        wait_fall;
        `CHK(bus_rdata, fw(10'h005))
        step(2);
        bus_rd(REG_IRQ_MASK, d);
        `CHK(d, 16'h0000)
        bus_rd(REG_STATUS, d);
        `CHK(d[ST_LOADER_ACTIVE], 1'b0)
        bus_rd(REG_IRQ_STATUS, d);
        `CHK(d, 16'h0001)
        bus_rd(12'h3FF, d);
        `CHK(d, fw(10'h3FF))
        $display("t_boot done");
    endtask

    task automatic t_irq;
        logic [DATA_W-1:0] d;
        int n;
        bus_wr(REG_IRQ_MASK, 16'h0001);
        step(2);
        `CHK(irq_n, 1'b0)
        bus_wr(REG_IRQ_STATUS, 16'h0001);
        step(2);
        `CHK(irq_n, 1'b1)
        bus_wr(REG_IRQ_MASK, 16'h0000);
        trig;
        step(2);
        bus_rd(REG_IRQ_STATUS, d);
        `CHK(d, 16'h0004)
        `CHK(irq_n, 1'b1)
        bus_wr(REG_IRQ_STATUS, 16'h0004);
        bus_wr(REG_CTRL, 16'h0002);
        bus_wr(REG_IRQ_MASK, 16'h0004);
        step(70);
        fork
            trig;
            measure(1'b1, 1'b0, n);
        join
        `CHK(n, PULSE_CYC)
        `CHK(irq_n, 1'b1)
        $display("t_irq done");
    endtask

    // A second trigger inside the pulse must not stretch it.
    task automatic t_dma;
        int n;
        step(70);
        `CHK(transfer_request_out, 1'b1)
        fork
            trig;
            begin
                repeat (20) @(posedge clk);
                trig;
            end
            measure(1'b0, 1'b0, n);
        join
        `CHK(n, PULSE_CYC)
        bus_wr(REG_DMA_CTRL, 16'h0001);
        step(3);
        `CHK(transfer_request_out, 1'b0)
        fork
            trig;
            measure(1'b0, 1'b1, n);
        join
        `CHK(n, PULSE_CYC)
        $display("t_dma done");
    endtask

    task automatic t_sleep;
        logic [DATA_W-1:0] d;
        step(70);
        bus_wr(REG_IRQ_STATUS, 16'h0007);
        bus_wr(REG_IRQ_MASK, 16'h0002);
        bus_wr(REG_CTRL, 16'h0001);
        step(2);
        bus_rd(REG_STATUS, d);
        `CHK(d[ST_SLEEPING], 1'b1)
        @(posedge clk);
        deep_sleep_control <= ~deep_sleep_control;
        bus_rd(REG_IRQ_MASK, d);
        `CHK(d, 16'h0000)
        step(DATA_VALID_CYC + 5);
        bus_rd(REG_IRQ_MASK, d);
        `CHK(d, 16'h0002)
        bus_rd(REG_IRQ_STATUS, d);
        `CHK(d, 16'h0002)
        `CHK(irq_n, 1'b0)
        $display("t_sleep done");
    endtask

    // Reset in mid-run with an erase pending and a slow flash.
    task automatic t_erase;
        logic [DATA_W-1:0] d;
        int n;
        lat = 4'h3;
        do_reset(1'b1);
        for (n = 0; n < 100 && flash_rd_req !== 1'b1; n++) step(1);
        `CHK(n >= EXT && n <= EXT + 8, 1'b1)
        flash_erase_busy <= 1'b0;
        wait_fall;
        step(2);
        bus_rd(REG_STATUS, d);
        `CHK(d[ST_ERASE_EXT], 1'b1)
        `CHK(d[ST_LOADER_ACTIVE], 1'b0)
        $display("t_erase done");
    endtask

    task automatic wrap_up;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // A hang is counted as a mismatch and cut short.
    always @(posedge clk) begin
        cyc_count++;
        if (cyc_count == 30000) begin
            err_count++;
            $display("ERROR %0t run took too long", $time);
            wrap_up;
        end
    end

    initial begin
        rstn = 1'b0;
        flash_erase_busy = 1'b0;
        deep_sleep_control = 1'b0;
        dma_trigger = 1'b0;
        lat = 4'h1;
        bus_req = '0;
        t_boot;
        t_irq;
        t_dma;
        t_sleep;
        t_erase;
        wrap_up;
    end
endmodule

bind rbds_sequencer rbds_monitor #(.ERASE_EXT(ERASE_EXT)) i_rbds_monitor (.clk(clk), .rstn(rstn),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
    .flash_rsp(flash_rsp), .flash_erase_busy(flash_erase_busy), .download_pending(download_pending),
    .transfer_request_out(transfer_request_out), .irq_n(irq_n));
`default_nettype wire
